/* verif/pcp_props.sv */
`timescale 1ns/1ps
module pcp_props #(
    parameter RAIL_CYCLES = 50
) (
    input wire        sys_clk,
    input wire        reset_n,
    input wire        clk_en,
    input wire        avs_read,
    input wire        avs_write,
    input wire        avs_waitrequest,
    input wire        adc_start,
    input wire [2:0]  adc_channel,
    input wire [23:0] fast_trip_threshold,
    input wire [3:0]  fast_cmp_hit,
    input wire        gd_trip,
    input wire [5:0]  pwm_raw,
    input wire [5:0]  pulse_width_output,
    input wire [47:0] balance_adjust,
    input wire [3:0]  rail_kill
);
    wire [3:0]  hits;
    wire [10:0] bal_sum;
    wire        req;
    assign req = avs_read | avs_write;
    assign hits = fast_cmp_hit & {|fast_trip_threshold[23:18],
        |fast_trip_threshold[17:12], |fast_trip_threshold[11:6],
        |fast_trip_threshold[5:0]};
    assign bal_sum = balance_adjust[7:0] + balance_adjust[15:8]
        + balance_adjust[23:16] + balance_adjust[31:24]
        + balance_adjust[39:32] + balance_adjust[47:40];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_req;
        req && avs_waitrequest && clk_en;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_req |=> s_ans)
        else $error("bus answer missing or too long");
    AST_BUS_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(req))
        else $error("answer without request");
    AST_ADC_PULSE: assert property (adc_start && clk_en |=> !adc_start)
        else $error("conversion start longer than one cycle");
    AST_ADC_CHAN: assert property (adc_start |-> adc_channel <= 3'h5)
        else $error("conversion of a channel that does not exist");
    AST_FAST_KILL: assert property (hits != 4'h0 |=> rail_kill != 4'h0)
        else $error("enabled comparator hit without shutdown");
    // sampled reset_n keeps the release edge out of the antecedent
    AST_GATE_PASS: assert property (
        reset_n && clk_en && rail_kill == 4'h0 && hits == 4'h0 && !gd_trip |=>
        rail_kill != 4'h0 || pulse_width_output == $past(pwm_raw))
        else $error("healthy phase output not passed through");
    AST_BAL_SUM: assert property (bal_sum == 11'h300)
        else $error("balance adjustments changed their total");
    AST_BAL_POS: assert property (
        balance_adjust[7:0] != 8'h00 && balance_adjust[15:8] != 8'h00 &&
        balance_adjust[23:16] != 8'h00 && balance_adjust[31:24] != 8'h00 &&
        balance_adjust[39:32] != 8'h00 && balance_adjust[47:40] != 8'h00)
        else $error("balance adjustment reached zero");
endmodule // pcp_props

bind pcp_top pcp_props #(.RAIL_CYCLES(RAIL_CYCLES)) i_props (
    .sys_clk, .reset_n, .clk_en, .avs_read, .avs_write, .avs_waitrequest,
    .adc_start, .adc_channel, .fast_trip_threshold, .fast_cmp_hit,
    .gd_trip, .pwm_raw, .pulse_width_output, .balance_adjust, .rail_kill);

/* verif/pcp_stage_model.sv */
`timescale 1ns/1ps
module pcp_stage_model (
    input  wire        sys_clk,
    input  wire        adc_start,
    input  wire [2:0]  adc_channel,
    input  wire [71:0] sense,
    input  wire        slow,
    input  wire        fault_req,
    output reg         adc_done,
    output reg  [11:0] adc_data,
    output wire        gd_trip
);
    reg [2:0] ch;
    reg [3:0] cnt;
    reg       busy;
    // driver flags a high-side fault as a high level
    assign gd_trip = fault_req;
    initial begin
        adc_done = 1'h0;
        adc_data = 12'h0;
        busy = 1'h0;
        cnt = 4'h0;
        ch = 3'h0;
    end
    always @(posedge sys_clk) begin
        adc_done <= 1'h0;
        if (adc_start) begin
            busy <= 1'h1;
            ch <= adc_channel;
            cnt <= slow ? 4'h6 : 4'h0;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'h0;
            adc_done <= 1'h1;
            adc_data <= sense[ch * 12 +: 12];
        end else begin
            // result is not held after done drops
            adc_data <= ~adc_data;
        end
    end
endmodule // pcp_stage_model

/* verif/phase_current_protection_test.sv */
`timescale 1ns/1ps
module phase_current_protection_test;
    reg         sys_clk = 1'h0;
    reg         reset_n = 1'h0;
    reg  [7:0]  avs_address = 8'h00;
    reg         avs_read = 1'h0;
    reg         avs_write = 1'h0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  fast_cmp_hit = 4'h0;
    reg  [47:0] rail_vout = 48'h0;
    reg  [5:0]  pwm_raw = 6'h0;
    reg  [5:0]  sre_raw = 6'h0;
    reg  [71:0] sense = 72'h0;
    reg         slow = 1'h0;
    reg         fault_req = 1'h0;
    reg         stepped = 1'h0;
    reg         clk_en = 1'h1;
    reg  [47:0] held;
    reg  [31:0] rd;
    reg  [7:0]  hole;
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     cycles = 0;
    integer     n;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, adc_start, adc_done, gd_trip, irq;
    wire [2:0]  adc_channel;
    wire [11:0] adc_data;
    wire [23:0] fast_trip_threshold;
    wire [5:0]  pulse_width_output, sync_rectifier_enable;
    wire [47:0] balance_adjust;
    wire [3:0]  foldback_active, vref_step_down, rail_kill;

    pcp_top #(.RAIL_CYCLES(50)) i_dut (
        .sys_clk, .reset_n, .clk_en, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .adc_start, .adc_channel, .adc_done, .adc_data,
        .fast_trip_threshold, .fast_cmp_hit, .gd_trip, .rail_vout,
        .pwm_raw, .sre_raw, .pulse_width_output, .sync_rectifier_enable,
        .balance_adjust, .foldback_active, .vref_step_down, .rail_kill,
        .irq);
    pcp_stage_model i_stage (
        .sys_clk, .adc_start, .adc_channel, .sense, .slow, .fault_req,
        .adc_done, .adc_data, .gd_trip);

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        pwm_raw <= 6'($urandom);
        sre_raw <= 6'($urandom);
        if (vref_step_down[0]) stepped <= 1'h1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end

    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk_reg(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error %0t reg %h exp %h", $time, got, exp);
            end
        end
    endtask
    task chk_port(input [47:0] got, input [47:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error %0t port %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= ~wr;
            n = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'h0 && n < 50) begin
                n = n + 1;
                @(posedge sys_clk);
            end
            rd = avs_readdata;
            if (n == 50) bad_count = bad_count + 1;
            avs_write <= 1'h0;
            avs_read <= 1'h0;
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] m, input [31:0] exp);
        begin
            bus(1'h0, a, 32'h0);
            chk_reg(rd & m, exp);
        end
    endtask
    task wait_kill(input integer r, input integer lim);
        begin
            for (n = 0; rail_kill[r] !== 1'h1 && n < lim; n = n + 1)
                @(posedge sys_clk);
            chk_port(rail_kill[r], 48'h1);
        end
    endtask
    function [15:0] f_scale(input [11:0] d, input [15:0] g, input [15:0] o);
        integer t;
        begin
            t = (d * g) >> 8;
            t = t + $signed(o);
            f_scale = (t < 0) ? 16'h0 : (t > 65535) ? 16'hFFFF : t[15:0];
        end
    endfunction
    function [18:0] f_filt(input [18:0] s, input [15:0] lim);
        reg [18:0] y;
        begin
            y = 19'h0;
            while (y <= lim) y = y + ((s - y) >> 2);
            f_filt = y;
        end
    endfunction

    initial begin
        n = $urandom(12);
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'h1;
        chk_port(balance_adjust, {6{8'h80}});
        rdchk(8'h0C, 32'hFFFFFFFF, 32'h100);
        rdchk(8'h14, 32'hFFFFFFFF, 32'hFFFF);
        rdchk(8'h04, 32'hFFFFFFFF, 32'hE40);
        hole = 8'hC0 + 8'($urandom % 16) * 8'h04;
        bus(1'h1, hole, $urandom);
        rdchk(hole, 32'hFFFFFFFF, 32'h0);
        // phases 4 and 5 share rails 0 and 1
        bus(1'h1, 8'h04, 32'h4E4);
        bus(1'h1, 8'h34, 32'h3);
        bus(1'h1, 8'h08, 32'h80103F);
        rdchk(8'h08, 32'hFFFFFFFF, 32'h80103F);
        chk_port(fast_trip_threshold, 48'h80103F);
        fast_cmp_hit <= 4'h2;
        repeat (10) @(posedge sys_clk);
        chk_port(rail_kill, 48'h0);
        fast_cmp_hit <= 4'h1;
        repeat (2) @(posedge sys_clk);
        chk_port({rail_kill[0], pulse_width_output & 6'h11,
                  sync_rectifier_enable & 6'h11}, 48'h1000);
        fast_cmp_hit <= 4'h0;
        repeat (2) @(posedge sys_clk);
        chk_port(irq, 48'h1);
        rdchk(8'h30, 32'h3, 32'h2);
        rdchk(8'h30, 32'h3, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk_port(irq, 48'h0);
        bus(1'h1, 8'h00, 32'hA);
        fault_req <= 1'h1;
        wait_kill(2, 1400);
        fault_req <= 1'h0;
        rdchk(8'h30, 32'h1, 32'h1);
        bus(1'h1, 8'h00, 32'hB);
        fault_req <= 1'h1;
        repeat (30) @(posedge sys_clk);
        chk_port(rail_kill, 48'h0);
        fault_req <= 1'h0;
        bus(1'h1, 8'h00, 32'h2);
        bus(1'h1, 8'h0C, 32'h200);
        bus(1'h1, 8'h14, 32'h100);
        bus(1'h1, 8'h24, 32'h1);
        // filter must still be empty, so load only between evaluations
        for (n = 0; !(adc_done === 1'h1 && adc_channel === 3'h4)
             && n < 200; n = n + 1) @(posedge sys_clk);
        sense <= {12'h0, 12'h078, 36'h0, 12'h078};
        bus(1'h1, 8'h10, 32'h10);
        wait_kill(0, 600);
        rdchk(8'h40, 32'h7FFFF, f_filt(19'(2 * f_scale(12'h078, 16'h200,
              16'h10)), 16'h100));
        bus(1'h1, 8'h24, 32'h0);
        bus(1'h1, 8'h28, 32'h100);
        bus(1'h1, 8'h2C, 32'h1);
        rail_vout <= 48'h800;
        slow <= 1'h1;
        sense <= {12'h0, 12'h060, 36'h0, 12'h090};
        bus(1'h1, 8'h00, 32'h2);
        for (n = 0; foldback_active[0] !== 1'h1 && n < 200; n = n + 1)
            @(posedge sys_clk);
        chk_port(foldback_active[0], 48'h1);
        repeat (300) @(posedge sys_clk);
        chk_port(stepped, 48'h1);
        chk_port({balance_adjust[7:0] < 8'h80,
                  balance_adjust[39:32] > 8'h80}, 48'h3);
        chk_port(balance_adjust[15:8], 48'h80);
        rail_vout <= 48'h050;
        wait_kill(0, 300);
        // freeze longer than one rail period; no evaluation may step
        clk_en <= 1'h0;
        @(posedge sys_clk);
        held = balance_adjust;
        repeat (60) @(posedge sys_clk);
        chk_port(balance_adjust, held);
        clk_en <= 1'h1;
        report_and_stop;
    end
endmodule // phase_current_protection_test

/* verilog/pcp_defs.vh */
`ifndef PCP_DEFS_VH
`define PCP_DEFS_VH
`define PCP_CLK_MHZ       100
`define PCP_RAIL_US       200
`define PCP_RAIL_CYCLES   (`PCP_RAIL_US * `PCP_CLK_MHZ)
`define PCP_FILT_SHIFT    2
`define PCP_BAL_STEP      8'h01
`define PCP_BAL_INIT      8'h80
`define PCP_A_CTRL        8'h00
`define PCP_A_MAP         8'h04
`define PCP_A_FAST        8'h08
`define PCP_A_GAIN        8'h0C
`define PCP_A_OFFS        8'h10
`define PCP_A_LIM0        8'h14
`define PCP_A_OCACT       8'h24
`define PCP_A_FLOOR       8'h28
`define PCP_A_FLACT       8'h2C
`define PCP_A_STAT        8'h30
`define PCP_A_MASK        8'h34
`define PCP_A_RAIL        8'h38
`define PCP_A_CUR0        8'h40
`define PCP_CTRL_SEQ      0
`define PCP_CTRL_CLR      1
`define PCP_ST_GDTRIP     0
`define PCP_ST_FAST       1
`define PCP_ST_OC         2
`define PCP_ST_FLOOR      3
`define PCP_ST_SAMPLE     4
`define PCP_RST_MAP       12'hE40
`define PCP_RST_GAIN      16'h0100
`define PCP_RST_LIM       16'hFFFF
`endif

/* verilog/pcp_top.v */
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pcp_defs.vh"
module pcp_top #(
    parameter RAIL_CYCLES = `PCP_RAIL_CYCLES
) (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        clk_en,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         adc_start,
    output reg  [2:0]  adc_channel,
    input  wire        adc_done,
    input  wire [11:0] adc_data,
    output reg  [23:0] fast_trip_threshold,
    input  wire [3:0]  fast_cmp_hit,
    input  wire        gd_trip,
    input  wire [47:0] rail_vout,
    input  wire [5:0]  pwm_raw,
    input  wire [5:0]  sre_raw,
    output reg  [5:0]  pulse_width_output,
    output reg  [5:0]  sync_rectifier_enable,
    output reg  [47:0] balance_adjust,
    output reg  [3:0]  foldback_active,
    output reg  [3:0]  vref_step_down,
    output reg  [3:0]  rail_kill,
    output reg         irq
);
    localparam S_IDLE  = 5'b00001;
    localparam S_START = 5'b00010;
    localparam S_WAIT  = 5'b00100;
    localparam S_EVAL  = 5'b01000;
    localparam S_BAL   = 5'b10000;

    function [1:0] rail_of;
        input [11:0] m;
        input [2:0]  p;
        begin
            rail_of = m[p*2 +: 2];
        end
    endfunction

    function [15:0] pcp_scale;
        input [11:0] d;
        input [15:0] g;
        input [15:0] o;
        reg [27:0]        p;
        reg signed [21:0] s;
        begin
            p = d * g;
            s = $signed({2'b00, p[27:8]}) + $signed({{6{o[15]}}, o});
            if (s < 0)
                pcp_scale = 16'h0000;
            else if (s > $signed(22'h00FFFF))
                pcp_scale = 16'hFFFF;
            else
                pcp_scale = s[15:0];
        end
    endfunction

    reg        seq_mode;
    reg [1:0]  trip_rail;
    reg [1:0]  rail_last;
    reg [11:0] phase_map;
    reg [15:0] cur_gain;
    reg [15:0] cur_offset;
    reg [15:0] oc_limit [0:3];
    reg [3:0]  oc_action;
    reg [11:0] floor_volt;
    reg [3:0]  floor_action;
    reg [4:0]  status;
    reg [4:0]  mask;
    reg [18:0] filt [0:3];
    reg [15:0] cur [0:5];
    reg [18:0] sum;
    reg [4:0]  state;
    reg [1:0]  rail_ptr;
    reg [2:0]  ph;
    reg [14:0] tick;
    reg        gd_seen;

    wire acc = (avs_read | avs_write) & ~avs_waitrequest;
    wire wr  = acc & avs_write;
    wire rd  = acc & avs_read;
    wire clr_req = wr && avs_address == `PCP_A_CTRL
                   && avs_writedata[`PCP_CTRL_CLR];

    // comparator live only with a nonzero code
    reg [3:0] fast_fault;
    reg [3:0] fast_rail_hit;
    integer k;
    always @* begin
        fast_rail_hit = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            fast_fault[k] = fast_cmp_hit[k]
                            && fast_trip_threshold[k*6 +: 6] != 6'h00;
            if (fast_fault[k])
                fast_rail_hit[rail_of(phase_map, k[2:0])] = 1'b1;
        end
    end

    // level from the driver; sequencing mode masks it entirely
    wire gd_fault = gd_trip & ~seq_mode;

    // evaluation of the rail just sampled
    wire signed [19:0] fdiff = $signed({1'b0, sum})
                             - $signed({1'b0, filt[rail_ptr]});
    wire signed [19:0] fstep = fdiff >>> `PCP_FILT_SHIFT;
    wire [18:0] filt_new = filt[rail_ptr] + fstep[18:0];
    wire over = filt_new > {3'b000, oc_limit[rail_ptr]};
    wire [11:0] vout_now = rail_vout[rail_ptr*12 +: 12];
    wire below = vout_now < floor_volt;

    // highest and lowest phase of the rail, for balancing
    reg [2:0]  hi_ph;
    reg [2:0]  lo_ph;
    reg [2:0]  members;
    reg        hi_ok;
    reg        lo_ok;
    integer j;
    always @* begin
        hi_ph   = 3'd0;
        lo_ph   = 3'd0;
        members = 3'd0;
        hi_ok   = 1'b0;
        lo_ok   = 1'b0;
        for (j = 0; j < 6; j = j + 1) begin
            if (rail_of(phase_map, j[2:0]) == rail_ptr) begin
                if (!hi_ok || cur[j] > cur[hi_ph]) begin
                    hi_ph = j[2:0];
                    hi_ok = 1'b1;
                end
                if (!lo_ok || cur[j] < cur[lo_ph]) begin
                    lo_ph = j[2:0];
                    lo_ok = 1'b1;
                end
                members = members + 3'd1;
            end
        end
    end
    wire [7:0] adj_hi = balance_adjust[hi_ph*8 +: 8];
    wire [7:0] adj_lo = balance_adjust[lo_ph*8 +: 8];
    // floor of one step keeps every phase duty positive
    wire bal_go = members > 3'd1 && cur[hi_ph] != cur[lo_ph]
                  && adj_hi > `PCP_BAL_STEP
                  && adj_lo <= 8'hFF - `PCP_BAL_STEP;

    // event flags, pulses except the fast-trip level, registered into sticky status
    reg [4:0] ev;
    always @* begin
        ev = 5'h00;
        ev[`PCP_ST_GDTRIP] = gd_fault & ~gd_seen;
        ev[`PCP_ST_FAST]   = |fast_fault;
        ev[`PCP_ST_OC]     = state == S_EVAL && over;
        ev[`PCP_ST_FLOOR]  = state == S_EVAL && over && below
                             && foldback_active[rail_ptr]
                             && floor_action[rail_ptr];
        ev[`PCP_ST_SAMPLE] = state == S_EVAL;
    end

    reg [3:0] kill_set;
    always @* begin
        kill_set = fast_rail_hit;
        if (gd_fault)
            kill_set[trip_rail] = 1'b1;
        if (state == S_EVAL && over && oc_action[rail_ptr])
            kill_set[rail_ptr] = 1'b1;
        if (ev[`PCP_ST_FLOOR])
            kill_set[rail_ptr] = 1'b1;
    end

    reg [31:0] rdata;
    always @* begin
        rdata = 32'h00000000;
        case (avs_address)
            `PCP_A_CTRL:  rdata = {26'h0, rail_last, trip_rail, 1'b0,
                                   seq_mode};
            `PCP_A_MAP:   rdata = {20'h0, phase_map};
            `PCP_A_FAST:  rdata = {8'h00, fast_trip_threshold};
            `PCP_A_GAIN:  rdata = {16'h0000, cur_gain};
            `PCP_A_OFFS:  rdata = {16'h0000, cur_offset};
            `PCP_A_OCACT: rdata = {28'h0, oc_action};
            `PCP_A_FLOOR: rdata = {20'h0, floor_volt};
            `PCP_A_FLACT: rdata = {28'h0, floor_action};
            `PCP_A_STAT:  rdata = {27'h0, status};
            `PCP_A_MASK:  rdata = {27'h0, mask};
            `PCP_A_RAIL:  rdata = {24'h0, foldback_active, rail_kill};
            default: begin
                if (avs_address[7:4] == 4'h1 && avs_address >= `PCP_A_LIM0
                    || avs_address == 8'h20)
                    rdata = {16'h0, oc_limit[avs_address[3:2] - 2'd1]};
                if (avs_address[7:4] == 4'h4 && avs_address[1:0] == 2'b00)
                    rdata = {13'h0, filt[avs_address[3:2]]};
            end
        endcase
    end

    integer i;
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            avs_readdata          <= 32'h00000000;
            avs_waitrequest       <= 1'b1;
            seq_mode              <= 1'b0;
            trip_rail             <= 2'b00;
            rail_last             <= 2'b00;
            phase_map             <= `PCP_RST_MAP;
            fast_trip_threshold   <= 24'h000000;
            cur_gain              <= `PCP_RST_GAIN;
            cur_offset            <= 16'h0000;
            oc_action             <= 4'h0;
            floor_volt            <= 12'h000;
            floor_action          <= 4'h0;
            status                <= 5'h00;
            mask                  <= 5'h00;
            irq                   <= 1'b0;
            rail_kill             <= 4'h0;
            gd_seen               <= 1'b0;
            pulse_width_output    <= 6'h00;
            sync_rectifier_enable <= 6'h00;
            balance_adjust        <= {6{`PCP_BAL_INIT}};
            foldback_active       <= 4'h0;
            vref_step_down        <= 4'h0;
            adc_start             <= 1'b0;
            adc_channel           <= 3'd0;
            sum                   <= 19'h00000;
            state                 <= S_IDLE;
            rail_ptr              <= 2'b00;
            ph                    <= 3'd0;
            tick                  <= 15'h0000;
            for (i = 0; i < 4; i = i + 1) begin
                oc_limit[i] <= `PCP_RST_LIM;
                filt[i]     <= 19'h00000;
            end
            for (i = 0; i < 6; i = i + 1)
                cur[i] <= 16'h0000;
        end else if (clk_en) begin
            // one-cycle answer, then the bus goes busy again
            avs_waitrequest <= ~(avs_waitrequest
                                 & (avs_read | avs_write));
            if (avs_waitrequest & avs_read)
                avs_readdata <= rdata;
            if (wr) begin
                case (avs_address)
                    `PCP_A_CTRL: begin
                        seq_mode  <= avs_writedata[`PCP_CTRL_SEQ];
                        trip_rail <= avs_writedata[3:2];
                        rail_last <= avs_writedata[5:4];
                    end
                    `PCP_A_MAP:   phase_map <= avs_writedata[11:0];
                    `PCP_A_FAST:  fast_trip_threshold <= avs_writedata[23:0];
                    `PCP_A_GAIN:  cur_gain <= avs_writedata[15:0];
                    `PCP_A_OFFS:  cur_offset <= avs_writedata[15:0];
                    `PCP_A_OCACT: oc_action <= avs_writedata[3:0];
                    `PCP_A_FLOOR: floor_volt <= avs_writedata[11:0];
                    `PCP_A_FLACT: floor_action <= avs_writedata[3:0];
                    `PCP_A_MASK:  mask <= avs_writedata[4:0];
                    default: begin
                        if (avs_address[7:4] == 4'h1
                            && avs_address >= `PCP_A_LIM0
                            || avs_address == 8'h20)
                            oc_limit[avs_address[3:2] - 2'd1]
                                <= avs_writedata[15:0];
                    end
                endcase
            end

            // read clears; an event in the same cycle survives
            status <= (rd && avs_address == `PCP_A_STAT
                       ? 5'h00 : status) | ev;
            irq    <= |(((rd && avs_address == `PCP_A_STAT
                          ? 5'h00 : status) | ev) & mask);
            gd_seen <= gd_fault;

            // latched rail shutdown; set wins over software clear
            rail_kill <= (clr_req ? 4'h0 : rail_kill) | kill_set;
            for (i = 0; i < 6; i = i + 1) begin
                pulse_width_output[i] <= pwm_raw[i]
                    & ~(rail_kill[rail_of(phase_map, i[2:0])]
                        | kill_set[rail_of(phase_map, i[2:0])]);
                sync_rectifier_enable[i] <= sre_raw[i]
                    & ~(rail_kill[rail_of(phase_map, i[2:0])]
                        | kill_set[rail_of(phase_map, i[2:0])]);
            end

            adc_start      <= 1'b0;
            vref_step_down <= 4'h0;
            tick <= (tick == RAIL_CYCLES - 1) ? 15'h0000 : tick + 15'h0001;

            case (state)
                S_IDLE: begin
                    // one rail per tick, rails taken round robin
                    if (tick == RAIL_CYCLES - 1) begin
                        rail_ptr <= (rail_ptr >= rail_last)
                                    ? 2'b00 : rail_ptr + 2'b01;
                        ph    <= 3'd0;
                        sum   <= 19'h00000;
                        state <= S_START;
                    end
                end
                S_START: begin
                    if (ph == 3'd6) begin
                        state <= S_EVAL;
                    end else if (rail_of(phase_map, ph) == rail_ptr) begin
                        adc_channel <= ph;
                        adc_start   <= 1'b1;
                        state       <= S_WAIT;
                    end else begin
                        ph <= ph + 3'd1;
                    end
                end
                S_WAIT: begin
                    if (adc_done) begin
                        cur[ph] <= pcp_scale(adc_data, cur_gain,
                                             cur_offset);
                        sum <= sum + {3'b000, pcp_scale(adc_data,
                                      cur_gain, cur_offset)};
                        ph    <= ph + 3'd1;
                        state <= S_START;
                    end
                end
                S_EVAL: begin
                    filt[rail_ptr] <= filt_new;
                    // foldback trims vref while current stays high
                    if (over && !oc_action[rail_ptr]) begin
                        foldback_active[rail_ptr] <= 1'b1;
                        vref_step_down[rail_ptr]  <= 1'b1;
                    end else begin
                        foldback_active[rail_ptr] <= 1'b0;
                    end
                    state <= S_BAL;
                end
                S_BAL: begin
                    if (bal_go) begin
                        balance_adjust[hi_ph*8 +: 8]
                            <= adj_hi - `PCP_BAL_STEP;
                        balance_adjust[lo_ph*8 +: 8]
                            <= adj_lo + `PCP_BAL_STEP;
                    end
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // pcp_top
